/* File: pcc_regs.svh */
`ifndef PCC_REGS_SVH
`define PCC_REGS_SVH
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Without bus, use fixed sizes, thresholds, enable.
// - Bus on control clock, 32-bit, 2-bit responses.
// - Clock enable low freezes state and outputs.
// - Control reset overrides clock enable.
// - Reset resynchronised into pixel domain for core.
// - Control bits: run, commit, bypass, pattern, resets.
// - Status: begun, done, error summary; resets zero.
// - Error flags: line short/long, frame early/late.
// - Interrupt enables bits 16-0 match status bits.
// - Read-only version fields.
// - Debug frame, line, pixel counters read-only.
// - Double-buffered frame dimensions, build-time reset.
// - Double-buffered temporal and spatial variance limits.
// - Double-buffered outlier age limit.
// - Candidate and corrected counts, read-only, reset zero.
// - Run flag acts immediately, no frame wait.
// - Run flag resets 0, fixed build runs.
// - Host copy moves to active at committed frame end.
// - Bypass passes samples only with debug built.
// - Status and error bits sticky, write-one clears.
// - Interrupt is OR of enabled status bits.
// - Frame-aligned reset at frame end or between frames, self-clearing.
////////////////////////////////////////////////////////////////////////////////

// Register byte offsets.
`define PCC_OFF_CONTROL   12'h000
`define PCC_OFF_STATUS    12'h004
`define PCC_OFF_ERROR     12'h008
`define PCC_OFF_IRQ_MASK  12'h00c
`define PCC_OFF_VERSION   12'h010
`define PCC_OFF_FRAMES    12'h014
`define PCC_OFF_LINES     12'h018
`define PCC_OFF_PIXELS    12'h01c
`define PCC_OFF_FRAME_DIM 12'h020
`define PCC_OFF_TEMP_VAR  12'h100
`define PCC_OFF_SPAT_VAR  12'h104
`define PCC_OFF_AGE       12'h108
`define PCC_OFF_CAND      12'h10c
`define PCC_OFF_CORR      12'h120

// Control field positions.
`define PCC_CTL_RUN     0
`define PCC_CTL_COMMIT  1
`define PCC_CTL_BYPASS  4
`define PCC_CTL_PATTERN 5
`define PCC_CTL_FSR     30
`define PCC_CTL_IMM     31

// Status field positions and implemented-bit masks.
`define PCC_ST_BEGUN    0
`define PCC_ST_DONE     1
`define PCC_ST_ERR      16
`define PCC_STATUS_MASK 17'h1_0003
`define PCC_ERROR_MASK  4'hf

// Double-buffered field masks and build-time reset values.
`define PCC_DIM_MASK       32'h1fff_1fff
`define PCC_TEMP_MASK      32'h0000_0fff
`define PCC_SPAT_MASK      32'h0000_ffff
`define PCC_AGE_MASK       32'h0000_ffff
`define PCC_FRAME_DIM_RST  32'h0438_0780
`define PCC_TEMP_VAR_RST   32'h0000_0040
`define PCC_SPAT_VAR_RST   32'h0000_0080
`define PCC_AGE_RST        32'h0000_0010

// Version value; the value is arbitrary.
`define PCC_VERSION_RST    32'h0001_0203

// Response code and soft reset stretch in control clock cycles.
`define PCC_RESP_OKAY      2'b00
`define PCC_RST_HOLD_CYC   6'd32

`endif

/* File: pcc_pkg.sv */
package pcc_pkg;

  // State of the register bank apart from the double-buffered registers.
  typedef struct packed {
    logic        aw_full;
    logic [11:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic        run;
    logic        commit;
    logic        bypass;
    logic        pattern;
    logic        fsr;
    logic        imm;
    logic [16:0] status;
    logic [3:0]  error;
    logic [16:0] mask;
    logic        irq;
    logic        in_frame;
    logic [5:0]  hold;
    logic        core_req_n;
    logic [31:0] frames;
    logic [31:0] lines;
    logic [31:0] pixels;
    logic [31:0] cand;
    logic [31:0] corr;
  } pcc_state_t;

  // Host and active copy of one double-buffered register.
  typedef struct packed {
    logic [31:0] host;
    logic [31:0] active;
  } pcc_dbuf_t;

  // Two synchroniser stages.
  typedef struct packed {
    logic stage1;
    logic stage2;
  } pcc_sync_t;

endpackage

/* File: pcc_reset_sync.sv */
`timescale 1ns/100ps
module pcc_reset_sync import pcc_pkg::*; (
  input  wire logic aclk,
  input  wire logic req_n,
  output logic      core_rst_n
);

  pcc_sync_t st_reg;
  pcc_sync_t st_next;

  // The first stage feeds only the second one.
  always_comb begin
    st_next.stage1 = req_n;
    st_next.stage2 = st_reg.stage1;
  end

  // Pixel clock registers; this path is itself the reset, so it has none.
  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  assign core_rst_n = st_reg.stage2;

endmodule

/* File: pcc_dbuf.sv */
`timescale 1ns/100ps
module pcc_dbuf import pcc_pkg::*; #(
  parameter logic [31:0] RST_VAL    = 32'h0000_0000,
  parameter logic [31:0] FIELD_MASK = 32'hffff_ffff
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic        commit,
  output logic      [31:0] host_q,
  output logic      [31:0] active_q
);

  pcc_dbuf_t st_reg;
  pcc_dbuf_t st_next;

  // Host writes land in the host copy; a commit copies the old host copy.
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.host = wr_data & FIELD_MASK;
    end
    if (commit) begin
      st_next.active = st_reg.host;
    end
  end

  // Both copies start at the build-time value.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '{host: RST_VAL, active: RST_VAL};
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign host_q   = st_reg.host;
  assign active_q = st_reg.active;

endmodule

/* File: pcc_ctrl_regs.sv */
`timescale 1ns/100ps
`include "pcc_regs.svh"
module pcc_ctrl_regs import pcc_pkg::*; #(
  parameter int HAS_BUS   = 1,
  parameter int HAS_DEBUG = 1
) (
  input  wire logic        mclk,
  input  wire logic        s_axi_aclken,
  input  wire logic        rst_n,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [31:0] s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             irq,
  input  wire logic        aclk,
  output logic             core_rst_n,
  output logic             run_flag,
  output logic             bypass_en,
  output logic             pattern_en,
  output logic      [31:0] frame_dimensions_act,
  output logic      [31:0] temporal_variance_limit_act,
  output logic      [31:0] spatial_variance_limit_act,
  output logic      [31:0] outlier_age_limit_act,
  input  wire logic        frame_begun_evt,
  input  wire logic        frame_done_evt,
  input  wire logic [3:0]  input_error_evt,
  input  wire logic        line_done_evt,
  input  wire logic        pixel_evt,
  input  wire logic [31:0] candidate_count_in,
  input  wire logic [31:0] corrected_count_in
);

  localparam logic [3:0][11:0] DB_OFF  = {`PCC_OFF_AGE, `PCC_OFF_SPAT_VAR,
                                          `PCC_OFF_TEMP_VAR, `PCC_OFF_FRAME_DIM};
  localparam logic [3:0][31:0] DB_RST  = {`PCC_AGE_RST, `PCC_SPAT_VAR_RST,
                                          `PCC_TEMP_VAR_RST, `PCC_FRAME_DIM_RST};
  localparam logic [3:0][31:0] DB_MASK = {`PCC_AGE_MASK, `PCC_SPAT_MASK,
                                          `PCC_TEMP_MASK, `PCC_DIM_MASK};
  localparam logic             BUS_ON  = (HAS_BUS != 0);
  localparam logic             DBG_ON  = (HAS_DEBUG != 0);

  pcc_state_t  st_reg;
  pcc_state_t  st_next;
  logic        ce;
  logic        wr_fire;
  logic        soft_rst;
  logic        commit_now;
  logic [32:0] rd_word;
  logic        rd_hit;
  logic [31:0] db_host [4];
  logic [31:0] db_act  [4];
  logic [31:0] rst_state_bits;

  assign ce = s_axi_aclken;
  assign rst_state_bits = 32'h0000_0000;

  // A write is done once both address and data are held and no answer is pending.
  assign wr_fire    = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
  assign soft_rst   = st_reg.imm || (st_reg.hold != 6'd0);
  assign commit_now = frame_done_evt && st_reg.commit;

  ////////////////////////////////////////////////////////////////////////////////

  // Double-buffered registers; writes are dropped in the fixed build.
  for (genvar i = 0; i < 4; i++) begin : g_dbuf
    pcc_dbuf #(
      .RST_VAL    (DB_RST[i]),
      .FIELD_MASK (DB_MASK[i])
    ) u_dbuf (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .ce       (ce),
      .wr_en    (BUS_ON && wr_fire && (st_reg.aw_addr[11:2] == DB_OFF[i][11:2])),
      .wr_data  (st_reg.w_data),
      .commit   (commit_now),
      .host_q   (db_host[i]),
      .active_q (db_act[i])
    );
  end

  // Core reset request crosses into the pixel clock domain.
  pcc_reset_sync u_reset_sync (
    .aclk       (aclk),
    .req_n      (st_reg.core_req_n),
    .core_rst_n (core_rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////////

  // Read decode; the top bit flags a mapped offset.
  always_comb begin
    rd_word = {1'b1, 32'h0000_0000};
    case ({s_axi_araddr[11:2], 2'b00})
      `PCC_OFF_CONTROL: begin
        rd_word[`PCC_CTL_RUN]     = st_reg.run;
        rd_word[`PCC_CTL_COMMIT]  = st_reg.commit;
        rd_word[`PCC_CTL_BYPASS]  = st_reg.bypass;
        rd_word[`PCC_CTL_PATTERN] = st_reg.pattern;
        rd_word[`PCC_CTL_FSR]     = st_reg.fsr;
        rd_word[`PCC_CTL_IMM]     = st_reg.imm;
      end
      `PCC_OFF_STATUS:    rd_word[16:0] = st_reg.status;
      `PCC_OFF_ERROR:     rd_word[3:0]  = st_reg.error;
      `PCC_OFF_IRQ_MASK:  rd_word[16:0] = st_reg.mask;
      `PCC_OFF_VERSION:   rd_word[31:0] = `PCC_VERSION_RST;
      `PCC_OFF_FRAMES:    rd_word[31:0] = st_reg.frames;
      `PCC_OFF_LINES:     rd_word[31:0] = st_reg.lines;
      `PCC_OFF_PIXELS:    rd_word[31:0] = st_reg.pixels;
      `PCC_OFF_FRAME_DIM: rd_word[31:0] = db_host[0];
      `PCC_OFF_TEMP_VAR:  rd_word[31:0] = db_host[1];
      `PCC_OFF_SPAT_VAR:  rd_word[31:0] = db_host[2];
      `PCC_OFF_AGE:       rd_word[31:0] = db_host[3];
      `PCC_OFF_CAND:      rd_word[31:0] = st_reg.cand;
      `PCC_OFF_CORR:      rd_word[31:0] = st_reg.corr;
      default:            rd_word = 33'h0_0000_0000;
    endcase
  end

  assign rd_hit = rd_word[32];

  ////////////////////////////////////////////////////////////////////////////////

  // Next state of the bank: bus channels, control, events and counters.
  always_comb begin
    st_next = st_reg;
    // Write address and data are taken independently.
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr[11:0];
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Event flags set after the write so that a same-cycle clear loses.
    if (wr_fire) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      if (BUS_ON) begin
        case ({st_reg.aw_addr[11:2], 2'b00})
          `PCC_OFF_CONTROL: begin
            st_next.run     = st_reg.w_data[`PCC_CTL_RUN];
            st_next.commit  = st_reg.w_data[`PCC_CTL_COMMIT];
            st_next.bypass  = st_reg.w_data[`PCC_CTL_BYPASS] && DBG_ON;
            st_next.pattern = st_reg.w_data[`PCC_CTL_PATTERN] && DBG_ON;
            st_next.fsr     = st_reg.w_data[`PCC_CTL_FSR];
            st_next.imm     = st_reg.w_data[`PCC_CTL_IMM];
          end
          `PCC_OFF_STATUS:   st_next.status = st_reg.status & ~st_reg.w_data[16:0];
          `PCC_OFF_ERROR:    st_next.error  = st_reg.error & ~st_reg.w_data[3:0];
          `PCC_OFF_IRQ_MASK: st_next.mask   = st_reg.w_data[16:0];
          default:           st_next.resp   = `PCC_RESP_OKAY;
        endcase
      end
    end
    // Status and error flags latch their events.
    if (!soft_rst) begin
      st_next.status[`PCC_ST_BEGUN] = st_next.status[`PCC_ST_BEGUN] || frame_begun_evt;
      st_next.status[`PCC_ST_DONE]  = st_next.status[`PCC_ST_DONE] || frame_done_evt;
      st_next.status[`PCC_ST_ERR]   = st_next.status[`PCC_ST_ERR] || (|input_error_evt);
      st_next.error = st_next.error | (input_error_evt & `PCC_ERROR_MASK);
    end
    st_next.status = st_next.status & `PCC_STATUS_MASK;
    // Read channel answers one request at a time.
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word[31:0];
    end
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready  = !st_next.w_full && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    st_next.resp    = `PCC_RESP_OKAY;
    // The fixed build runs permanently.
    if (!BUS_ON) begin
      st_next.run = 1'b1;
    end
    // Frame tracking decides when a frame-aligned reset may fire.
    if (frame_begun_evt) begin
      st_next.in_frame = 1'b1;
    end
    if (frame_done_evt) begin
      st_next.in_frame = 1'b0;
    end
    if (st_reg.hold != 6'd0) begin
      st_next.hold = st_reg.hold - 6'd1;
    end
    if (st_reg.fsr && (frame_done_evt || !st_reg.in_frame)) begin
      st_next.fsr  = 1'b0;
      st_next.hold = `PCC_RST_HOLD_CYC;
    end
    // Monitor counters, cleared together with the core.
    if (DBG_ON) begin
      st_next.frames = st_reg.frames + {31'h0000_0000, frame_done_evt};
      st_next.lines  = st_reg.lines + {31'h0000_0000, line_done_evt};
      st_next.pixels = st_reg.pixels + {31'h0000_0000, pixel_evt};
    end
    if (frame_done_evt) begin
      st_next.cand = candidate_count_in;
      st_next.corr = corrected_count_in;
    end
    if (soft_rst) begin
      st_next.in_frame = 1'b0;
      st_next.frames   = rst_state_bits;
      st_next.lines    = rst_state_bits;
      st_next.pixels   = rst_state_bits;
      st_next.cand     = rst_state_bits;
      st_next.corr     = rst_state_bits;
    end
    st_next.core_req_n = !(st_next.imm || (st_next.hold != 6'd0));
    st_next.irq        = |(st_next.status & st_next.mask);
  end

  // Reset wins over the clock enable; a low enable freezes everything.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.run     <= !BUS_ON;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state registers.
  assign s_axi_awready               = st_reg.awready;
  assign s_axi_wready                = st_reg.wready;
  assign s_axi_bvalid                = st_reg.bvalid;
  assign s_axi_bresp                 = st_reg.resp;
  assign s_axi_arready               = st_reg.arready;
  assign s_axi_rvalid                = st_reg.rvalid;
  assign s_axi_rdata                 = st_reg.rdata;
  assign s_axi_rresp                 = st_reg.resp;
  assign irq                         = st_reg.irq;
  assign run_flag                    = st_reg.run;
  assign bypass_en                   = st_reg.bypass;
  assign pattern_en                  = st_reg.pattern;
  assign frame_dimensions_act        = db_act[0];
  assign temporal_variance_limit_act = db_act[1];
  assign spatial_variance_limit_act  = db_act[2];
  assign outlier_age_limit_act       = db_act[3];

  ////////////////////////////////////////////////////////////////////////////////

  // Checks on the bank, sampled on the control clock.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // A write with both halves held, taken while enabled.
  sequence seq_wr_take;
    ce && wr_fire;
  endsequence

  // A control write taken while enabled.
  sequence seq_ctl_write;
    ce && wr_fire && (st_reg.aw_addr == `PCC_OFF_CONTROL);
  endsequence

  // A frame-aligned reset request seen between frames.
  sequence seq_fsr_idle;
    ce && st_reg.fsr && !st_reg.in_frame;
  endsequence

  a_reset_values: assert property ($rose(rst_n) |-> run_flag == !BUS_ON && !s_axi_bvalid && !irq)
    else $error("State after reset is wrong.");

  a_freeze_hold: assert property (!ce |=> $stable({s_axi_bvalid, s_axi_rvalid, s_axi_rdata, irq, run_flag}))
    else $error("Outputs moved while the clock enable was low.");

  a_write_answer: assert property (seq_wr_take |=> s_axi_bvalid && s_axi_bresp == `PCC_RESP_OKAY)
    else $error("Write was not answered with OKAY.");

  a_read_unmapped: assert property (ce && s_axi_arvalid && s_axi_arready && !rd_hit
                                    |=> s_axi_rvalid && s_axi_rdata == 32'h0000_0000)
    else $error("Unmapped read did not return zero.");

  a_run_immediate: assert property (seq_ctl_write |=> run_flag == (BUS_ON ? $past(st_reg.w_data[0]) : 1'b1))
    else $error("Run flag did not follow the control write.");

  a_status_sticky: assert property (ce && st_reg.status[`PCC_ST_DONE]
                                    && !(wr_fire && st_reg.aw_addr == `PCC_OFF_STATUS)
                                    |=> st_reg.status[`PCC_ST_DONE])
    else $error("Status bit dropped without a clear.");

  a_error_set: assert property (ce && !soft_rst && input_error_evt[0] |=> st_reg.error[0]
                                && st_reg.status[`PCC_ST_ERR])
    else $error("Error event was not latched.");

  a_irq_or: assert property (irq == |(st_reg.status & st_reg.mask))
    else $error("Interrupt does not match enabled status.");

  a_commit_copy: assert property (ce && commit_now |=> frame_dimensions_act == $past(db_host[0]))
    else $error("Committed frame end did not copy the host value.");

  a_hold_active: assert property (ce && !commit_now |=> $stable(outlier_age_limit_act))
    else $error("Active copy changed without a commit.");

  a_fsr_fire: assert property (seq_fsr_idle |=> !st_reg.fsr && st_reg.hold == `PCC_RST_HOLD_CYC
                               ##1 !st_reg.core_req_n)
    else $error("Frame-aligned reset did not fire and clear.");

endmodule

/* File: pcc_axi_master.sv */
`timescale 1ns/100ps
// Bus master model; ready-side stalls come from the caller.
module pcc_axi_master (
  input  wire logic        mclk,
  input  wire logic        s_axi_aclken,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_awaddr,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic      [31:0] s_axi_wdata,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic      [31:0] s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  // Idle bus from time zero.
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = {96{1'b0}};
  end

  // Full-word write; released lines show the inverse of the last value.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input int st, output logic [1:0] resp);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge mclk);
    #1 {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = {a, d, 2'b11};
    while (!(ad && dd)) begin
      @(posedge mclk);
      ad = ad | (s_axi_aclken & s_axi_awready);
      dd = dd | (s_axi_aclken & s_axi_wready);
      #1;
      if (ad && s_axi_awvalid) {s_axi_awvalid, s_axi_awaddr} = {1'b0, ~a};
      if (dd && s_axi_wvalid) {s_axi_wvalid, s_axi_wdata} = {1'b0, ~d};
    end
    repeat (st) @(posedge mclk);
    #1 s_axi_bready = 1'b1;
    do @(posedge mclk); while (!(s_axi_bvalid && s_axi_aclken));
    resp = s_axi_bresp;
    #1 s_axi_bready = 1'b0;
  endtask

  // Read; data and response are taken at the accepting edge.
  task automatic rd(input logic [31:0] a, input int st, output logic [31:0] d, output logic [1:0] resp);
    @(posedge mclk);
    #1 {s_axi_araddr, s_axi_arvalid} = {a, 1'b1};
    do @(posedge mclk); while (!(s_axi_arready && s_axi_aclken));
    #1 {s_axi_araddr, s_axi_arvalid} = {~a, 1'b0};
    repeat (st) @(posedge mclk);
    #1 s_axi_rready = 1'b1;
    do @(posedge mclk); while (!(s_axi_rvalid && s_axi_aclken));
    {d, resp} = {s_axi_rdata, s_axi_rresp};
    #1 s_axi_rready = 1'b0;
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
`include "pcc_regs.svh"
module tb_top;
  logic mclk, aclk, rst_n, s_axi_aclken, irq, core_rst_n, run_flag, bypass_en, pattern_en;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic frame_begun_evt, frame_done_evt, line_done_evt, pixel_evt;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [3:0]  input_error_evt;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, candidate_count_in, corrected_count_in, rv;
  logic [31:0] frame_dimensions_act, temporal_variance_limit_act, spatial_variance_limit_act, outlier_age_limit_act;
  logic [31:0] act [4];
  logic [31:0] ra [15] = '{0, 4, 8, 12, 16, 20, 24, 28, 32, 256, 260, 264, 268, 288, 512};
  logic [31:0] re [15] = '{0, 0, 0, 0, `PCC_VERSION_RST, 0, 0, 0, `PCC_FRAME_DIM_RST, `PCC_TEMP_VAR_RST,
                           `PCC_SPAT_VAR_RST, `PCC_AGE_RST, 0, 0, 0};
  logic [31:0] dm [4] = '{`PCC_DIM_MASK, `PCC_TEMP_MASK, `PCC_SPAT_MASK, `PCC_AGE_MASK};
  int failures = 0;
  int n_compared = 0;
  int stall = 0;

  assign act = '{frame_dimensions_act, temporal_variance_limit_act, spatial_variance_limit_act, outlier_age_limit_act};

  pcc_ctrl_regs pcc_ctrl_regs_inst (.mclk, .s_axi_aclken, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .irq, .aclk,
    .core_rst_n, .run_flag, .bypass_en, .pattern_en, .frame_dimensions_act, .temporal_variance_limit_act,
    .spatial_variance_limit_act, .outlier_age_limit_act, .frame_begun_evt, .frame_done_evt, .input_error_evt,
    .line_done_evt, .pixel_evt, .candidate_count_in, .corrected_count_in);

  pcc_axi_master pcc_axi_master_inst (.mclk, .s_axi_aclken, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  // Control clock at 50 MHz and an unrelated pixel clock.
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    aclk = 1'b0;
    #3;
    forever #13.7 aclk = ~aclk;
  end

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  // Reads a register and compares data and response.
  task automatic chk_reg(input logic [31:0] a, input logic [31:0] e);
    pcc_axi_master_inst.rd(a, stall, rv, resp);
    chk($sformatf("reg %h", a), e, rv);
    chk("rresp", {30'h0, `PCC_RESP_OKAY}, {30'h0, resp});
  endtask

  // Writes a register and compares the response.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    pcc_axi_master_inst.wr(a, d, stall, resp);
    chk("bresp", {30'h0, `PCC_RESP_OKAY}, {30'h0, resp});
  endtask

  // Raises an event input for one cycle.
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1'b1;
    @(posedge mclk);
    #1 s = 1'b0;
  endtask

  // Prints the verdict and ends the run.
  task automatic summarize;
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #400000;
    failures++;
    summarize();
  end

  // Main sequence.
  initial begin
    {s_axi_aclken, rst_n, frame_begun_evt, frame_done_evt, line_done_evt, pixel_evt} = 6'h20;
    {input_error_evt, candidate_count_in, corrected_count_in} = 68'h0;
    repeat (8) @(posedge mclk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 15; i++) chk_reg(ra[i], re[i]);
    wr(0, 32'h31);
    chk("ctl", 32'h7, {run_flag, bypass_en, pattern_en});
    chk_reg(0, 32'h31);
    wr(0, 32'h0);
    chk("run", 0, run_flag);
    wr(`PCC_OFF_VERSION, 32'hffff_ffff);
    wr(32'h200, 32'hffff_ffff);
    chk_reg(`PCC_OFF_VERSION, `PCC_VERSION_RST);
    chk_reg(32'h200, 0);
    // Host copies change, active copies wait for a committed frame end.
    stall = 3;
    wr(0, 32'h1);
    for (int i = 0; i < 4; i++) wr(ra[i + 8], 32'hffff_ffff);
    for (int i = 0; i < 4; i++) chk_reg(ra[i + 8], dm[i]);
    pulse(frame_done_evt);
    for (int i = 0; i < 4; i++) chk("act", re[i + 8], act[i]);
    wr(0, 32'h3);
    pulse(frame_done_evt);
    for (int i = 0; i < 4; i++) chk("act", dm[i], act[i]);
    stall = 0;
    // Sticky status, write-one clear and interrupt masking.
    wr(`PCC_OFF_STATUS, 32'hffff_ffff);
    pulse(frame_begun_evt);
    chk_reg(`PCC_OFF_STATUS, 1);
    chk("irq", 0, irq);
    wr(`PCC_OFF_IRQ_MASK, 1);
    chk("irq", 1, irq);
    wr(`PCC_OFF_STATUS, 2);
    chk_reg(`PCC_OFF_STATUS, 1);
    wr(`PCC_OFF_STATUS, 1);
    chk_reg(`PCC_OFF_STATUS, 0);
    @(posedge mclk);
    #1 input_error_evt = 4'hf;
    @(posedge mclk);
    #1 input_error_evt = 4'h0;
    chk_reg(`PCC_OFF_ERROR, 32'hf);
    chk_reg(`PCC_OFF_STATUS, 32'h1_0000);
    chk("irq", 0, irq);
    wr(`PCC_OFF_IRQ_MASK, 32'h1_0000);
    chk("irq", 1, irq);
    wr(`PCC_OFF_ERROR, 32'h4);
    chk_reg(`PCC_OFF_ERROR, 32'hb);
    // Immediate soft reset clears counters and holds the core.
    wr(0, 32'h8000_0001);
    repeat (4) @(posedge aclk);
    chk("core_rst_n", 0, core_rst_n);
    wr(0, 32'h1);
    repeat (4) @(posedge aclk);
    chk("core_rst_n", 1, core_rst_n);
    chk_reg(`PCC_OFF_FRAMES, 0);
    repeat (3) pulse(line_done_evt);
    repeat (5) pulse(pixel_evt);
    {candidate_count_in, corrected_count_in} = {32'h1234_5678, 32'h9abc_def0};
    pulse(frame_done_evt);
    for (int i = 5; i < 8; i++) chk_reg(ra[i], 2 * i - 9);
    chk_reg(`PCC_OFF_CAND, 32'h1234_5678);
    chk_reg(`PCC_OFF_CORR, 32'h9abc_def0);
    // Frame-aligned reset waits for the frame end, then clears itself.
    pulse(frame_begun_evt);
    wr(0, 32'h4000_0001);
    chk_reg(0, 32'h4000_0001);
    chk("core_rst_n", 1, core_rst_n);
    pulse(frame_done_evt);
    chk_reg(0, 32'h1);
    repeat (3) @(posedge aclk);
    chk("core_rst_n", 0, core_rst_n);
    repeat (50) @(posedge mclk);
    chk("core_rst_n", 1, core_rst_n);
    // Clock enable low ignores events; reset still wins over it.
    wr(`PCC_OFF_STATUS, 32'hffff_ffff);
    #1 s_axi_aclken = 1'b0;
    pulse(frame_begun_evt);
    s_axi_aclken = 1'b1;
    chk_reg(`PCC_OFF_STATUS, 0);
    #1 {s_axi_aclken, rst_n} = 2'b00;
    repeat (32) @(posedge mclk);
    #1 {s_axi_aclken, rst_n} = 2'b11;
    chk_reg(0, 0);
    chk("irq", 0, irq);
    summarize();
  end
endmodule
